// ---- rtl/fault_recorder_pkg.sv ----
// Package with register map, fault bit positions and reset values of the fault recorder.
package fault_recorder_pkg;
  // Register offsets on the plain register port (word index, byte address = 4 * index).
  localparam logic [3:0] OFF_FAULT_FLAGS = 4'h0;
  localparam logic [3:0] OFF_STATUS_CTRL = 4'h1;
  localparam logic [3:0] OFF_HANDLER_ADDR = 4'h2;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h3;
  localparam logic [3:0] OFF_CORE_STATE = 4'h4;
  localparam logic [3:0] OFF_IVT_LIMIT = 4'h5;
  // Fault flag bit positions.
  localparam int BIT_BAD_MEMREF = 1;
  localparam int BIT_ILL_SOFTWARE_INTERRUPT_INSTRUCTION = 5;
  localparam int BIT_ILL_OPCODE = 6;
  localparam int BIT_FPU = 7;
  localparam int BIT_ALU = 8;
  localparam int BIT_PAGE_PERM = 9;
  localparam int BIT_PAGE_MISS = 10;
  localparam int BIT_PRIVILEGE = 11;
  localparam int BIT_IO = 12;
  localparam int BIT_IN_HANDLER = 13;
  localparam int IRQ_ID_LSB = 24;
  // Status control bit positions.
  localparam int CTRL_HANDLING_EN = 1;
  localparam int CTRL_PAGING = 4;
  // Reset values.
  localparam logic [31:0] RST_FAULT_FLAGS = 32'h0000_0000;
  localparam logic [31:0] RST_STATUS_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_HANDLER_ADDR = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_MASK = 32'h0000_0000;
  // Reserved interrupt vector region limits (inclusive upper address).
  localparam logic [63:0] IVT_END_32 = 64'h0000_0000_0000_03F8;
  localparam logic [63:0] IVT_END_64 = 64'h0000_0000_0000_05F4;
  // Number of fault source inputs.
  localparam int NUM_SRC = 9;
endpackage

// ---- rtl/fault_event_if.sv ----
// Interface carrying collected fault events from the detector to the recorder core.
`timescale 1ns/1ps
interface fault_event_if;
  logic [31:0] setMask; // Fault flag bits to set this cycle.
  logic anyFault; // Some fault is raised this cycle.
  logic instrFault; // The fault came from an instruction.
  modport detector (output setMask, output anyFault, output instrFault);
  modport recorder (input setMask, input anyFault, input instrFault);
endinterface

// ---- rtl/fault_detect.sv ----
// Combinational fault classifier: maps source strobes and memory checks to flag bits.
`timescale 1ns/1ps
module fault_detect (
  input wire logic [fault_recorder_pkg::NUM_SRC-1:0] srcFault,
  input wire logic memAccess,
  input wire logic [63:0] memAddr,
  input wire logic wide64,
  input wire logic inHandler,
  fault_event_if.detector ev
);
  import fault_recorder_pkg::*;

  // Flag bit position for each source strobe index.
  function automatic int srcBit(input int i);
    case (i)
      0: srcBit = BIT_ILL_SOFTWARE_INTERRUPT_INSTRUCTION;
      1: srcBit = BIT_ILL_OPCODE;
      2: srcBit = BIT_FPU;
      3: srcBit = BIT_ALU;
      4: srcBit = BIT_PAGE_PERM;
      5: srcBit = BIT_PAGE_MISS;
      6: srcBit = BIT_PRIVILEGE;
      7: srcBit = BIT_IO;
      default: srcBit = BIT_BAD_MEMREF;
    endcase
  endfunction

  logic ivtHit; // Access falls in the reserved interrupt vector region.
  logic [31:0] srcMask; // Flags from source strobes.

  // Reserved region check; the limit depends on the address width variant.
  always_comb begin
    ivtHit = memAccess && (memAddr <= (wide64 ? IVT_END_64 : IVT_END_32));
  end

  // Each source strobe lights its own flag bit.
  always_comb begin
    srcMask = 32'h0000_0000;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (srcFault[i]) begin
        srcMask[srcBit(i)] = 1'b1;
      end
    end
  end

  // Merge events and tag faults raised inside an architecture interrupt handler.
  always_comb begin
    ev.setMask = srcMask;
    if (ivtHit) begin
      ev.setMask[BIT_BAD_MEMREF] = 1'b1;
    end
    ev.anyFault = (ev.setMask != 32'h0000_0000);
    if (ev.anyFault && inHandler) begin
      ev.setMask[BIT_IN_HANDLER] = 1'b1;
    end
    ev.instrFault = ev.anyFault && !srcFault[7];
  end
endmodule

// ---- rtl/cpu_fault_recorder.sv ----
// Fault recorder top: fault flags, handler redirect, halt and the register port.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
module cpu_fault_recorder (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic [fault_recorder_pkg::NUM_SRC-1:0] srcFault,
  input wire logic memAccess,
  input wire logic [63:0] memAddr,
  input wire logic wide64,
  input wire logic inHandler,
  input wire logic [7:0] handlerIrqId,
  input wire logic [31:0] faultPc,
  input wire logic taskLoad,
  input wire logic [31:0] taskStatus,
  input wire logic restart,
  output logic redirect,
  output logic [31:0] redirectAddr,
  output logic redirectLogical,
  output logic [31:0] restartPc,
  output logic halted,
  output logic pagingOn,
  output logic irq
);
  import fault_recorder_pkg::*;

  // Whole state of the recorder in one record.
  typedef struct packed {
    logic [31:0] faultFlags;   // Sticky fault flags with interrupt ID in the top octet.
    logic [31:0] statusCtrl;   // Status control: handling enable and paging select.
    logic [31:0] handlerAddr;  // Fault handler entry address.
    logic [31:0] irqMask;      // Interrupt mask, same layout as fault flags.
    logic [31:0] rdata;        // Registered read data.
    logic redirect;            // One-cycle pulse steering fetch to the handler.
    logic [31:0] redirectAddr; // Handler address presented with the pulse.
    logic redirectLogical;     // Handler address is logical.
    logic [31:0] restartPc;    // Address of the faulting instruction to restart.
    logic halted;              // Core stopped after an unhandled fault.
    logic irq;                 // Level interrupt output.
  } state_t;

  state_t cur; // Registered state.
  state_t next_cur; // Next state.
  fault_event_if ev (); // Events from the detector.
  logic [31:0] clearMask; // Flag bits software clears this cycle.
  logic [31:0] flagsSet; // Flags after this cycle's events.

  // Classifier for all fault sources and the reserved region check.
  fault_detect detector (
    .srcFault(srcFault),
    .memAccess(memAccess),
    .memAddr(memAddr),
    .wide64(wide64),
    .inHandler(inHandler),
    .ev(ev)
  );

  // Next-state logic: register writes, fault capture, redirect and halt.
  always_comb begin
    next_cur = cur;
    next_cur.redirect = 1'b0;
    clearMask = 32'h0000_0000;
    // Write-one-to-clear on the fault flags register.
    if (regWrite && regAddr == OFF_FAULT_FLAGS) begin
      clearMask = regWdata;
    end
    // Set wins over clear so a fault in the clearing cycle is kept.
    flagsSet = (cur.faultFlags & ~clearMask) | ev.setMask;
    if (ev.anyFault && inHandler) begin
      flagsSet[IRQ_ID_LSB +: 8] = handlerIrqId;
    end
    next_cur.faultFlags = flagsSet;
    // Other writable registers.
    if (regWrite) begin
      case (regAddr)
        OFF_STATUS_CTRL: next_cur.statusCtrl = regWdata;
        OFF_HANDLER_ADDR: next_cur.handlerAddr = regWdata;
        OFF_IRQ_MASK: next_cur.irqMask = regWdata;
        default: ;
      endcase
    end
    // A task switch loads that task's own paging selection.
    if (taskLoad) begin
      next_cur.statusCtrl[CTRL_PAGING] = taskStatus[CTRL_PAGING];
    end
    // Fault response while running.
    if (ev.anyFault && !cur.halted) begin
      if (cur.statusCtrl[CTRL_HANDLING_EN]) begin
        next_cur.redirect = 1'b1;
        next_cur.redirectAddr = cur.handlerAddr;
        next_cur.redirectLogical = cur.statusCtrl[CTRL_PAGING];
        if (ev.instrFault) begin
          next_cur.restartPc = faultPc;
        end
      end else begin
        next_cur.halted = 1'b1;
      end
    end
    // Only an explicit restart leaves the halted state.
    if (restart) begin
      next_cur.halted = 1'b0;
    end
    // Read data stands in the cycle after the strobe only.
    next_cur.rdata = 32'h0000_0000;
    if (regRead) begin
      case (regAddr)
        OFF_FAULT_FLAGS: next_cur.rdata = cur.faultFlags;
        OFF_STATUS_CTRL: next_cur.rdata = cur.statusCtrl;
        OFF_HANDLER_ADDR: next_cur.rdata = cur.handlerAddr;
        OFF_IRQ_MASK: next_cur.rdata = cur.irqMask;
        OFF_CORE_STATE: next_cur.rdata = {31'h0000_0000, cur.halted};
        OFF_IVT_LIMIT: next_cur.rdata = wide64 ? IVT_END_64[31:0] : IVT_END_32[31:0];
        default: next_cur.rdata = 32'h0000_0000;
      endcase
    end
    // Level interrupt from unmasked flag bits.
    next_cur.irq = |(next_cur.faultFlags & next_cur.irqMask);
  end

  // State register; handling starts disabled.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur <= '0;
      cur.faultFlags <= RST_FAULT_FLAGS;
      cur.statusCtrl <= RST_STATUS_CTRL;
      cur.handlerAddr <= RST_HANDLER_ADDR;
      cur.irqMask <= RST_IRQ_MASK;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state register.
  assign regRdata = cur.rdata;
  assign redirect = cur.redirect;
  assign redirectAddr = cur.redirectAddr;
  assign redirectLogical = cur.redirectLogical;
  assign restartPc = cur.restartPc;
  assign halted = cur.halted;
  assign pagingOn = cur.statusCtrl[CTRL_PAGING];
  assign irq = cur.irq;
endmodule

// ---- bench/cpu_fault_recorder_checker.sv ----
// Concurrent port checks for the fault recorder.
`timescale 1ns/1ps
module cpu_fault_recorder_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic [fault_recorder_pkg::NUM_SRC-1:0] srcFault,
  input wire logic memAccess,
  input wire logic [63:0] memAddr,
  input wire logic wide64,
  input wire logic [31:0] faultPc,
  input wire logic restart,
  input wire logic redirect,
  input wire logic [31:0] restartPc,
  input wire logic halted
);
  import fault_recorder_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Read data only stand in the answer cycle.
  rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside answer cycle");
  // A halt needs a fault cause one cycle before.
  halt_cause_a: assert property ($rose(halted) |-> $past(|srcFault || memAccess))
    else $error("halt without fault");
  // Only a restart ends a halt.
  halt_hold_a: assert property ($fell(halted) |-> $past(restart))
    else $error("halt ended without restart");
  // A redirect needs a fault cause one cycle before.
  redirect_cause_a: assert property (redirect |-> $past(|srcFault || memAccess))
    else $error("redirect without fault");
  // A halted core is never redirected.
  redirect_halt_a: assert property (redirect |-> !halted)
    else $error("redirect while halted");
  // An instruction fault returns to its own address.
  restart_pc_a: assert property (redirect && !$past(srcFault[7]) |-> restartPc == $past(faultPc))
    else $error("restart address wrong");
  // Any fault source ends in a halt or a redirect.
  src_react_a: assert property (|srcFault && !restart |=> halted || redirect)
    else $error("fault ignored");
  // Vector region accesses are faults.
  region_hit_a: assert property (memAccess && !restart &&
    memAddr <= (wide64 ? IVT_END_64 : IVT_END_32) |=> halted || redirect)
    else $error("reserved access ignored");
endmodule
bind cpu_fault_recorder cpu_fault_recorder_checker i_checker (.*);

// ---- bench/cpu_fault_recorder_tb_top.sv ----
// Self-checking bench for the fault recorder.
`timescale 1ns/1ps
module cpu_fault_recorder_tb_top;
  import fault_recorder_pkg::*;
  logic clock = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, memAccess = 1'b0;
  logic wide64 = 1'b0, inHandler = 1'b0, taskLoad = 1'b0, restart = 1'b0, rdPend = 1'b0;
  logic redirect, redirectLogical, halted, pagingOn, irq;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] handlerIrqId = 8'h0;
  logic [31:0] regWdata = 32'h0, faultPc = 32'h0, taskStatus = 32'h0;
  logic [31:0] regRdata, redirectAddr, restartPc, acc, pc, ha;
  logic [NUM_SRC-1:0] srcFault = '0;
  logic [63:0] memAddr = 64'h0;
  logic [31:0] expQ[$]; // Expected read data, oldest first.
  int err_total = 0, checks_done = 0;
  int bt[9] = '{BIT_ILL_SOFTWARE_INTERRUPT_INSTRUCTION, BIT_ILL_OPCODE, BIT_FPU, BIT_ALU, BIT_PAGE_PERM,
    BIT_PAGE_MISS, BIT_PRIVILEGE, BIT_IO, BIT_BAD_MEMREF};
  cpu_fault_recorder i_cpu_fault_recorder (.*);
  always #2 clock = ~clock;
  // Compares a word and counts the result.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Compares a flag and counts the result.
  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  // Read data are compared in the cycle after the strobe.
  always @(posedge clock) begin
    if (rdPend) chk(regRdata, expQ.pop_front());
    rdPend <= regRead;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge clock);
    regRead <= 1'b0;
  endtask
  // One-cycle fault event; a zero source mask means a memory access.
  task automatic ev(input logic [NUM_SRC-1:0] s, input logic [63:0] a, input logic h, r);
    @(posedge clock);
    pc = $urandom;
    srcFault <= s;
    memAccess <= (s == '0);
    memAddr <= a;
    faultPc <= pc;
    @(posedge clock);
    srcFault <= '0;
    memAccess <= 1'b0;
    #1;
    chkb(halted, h);
    chkb(redirect, r);
  endtask
  task automatic rs;
    @(posedge clock);
    restart <= 1'b1;
    @(posedge clock);
    restart <= 1'b0;
    #1;
    chkb(halted, 1'b0);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog against a hang.
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    $display("unexpected at %0t: timeout", $time);
    conclude;
  end
  initial begin
    pc = $urandom(94);
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(OFF_FAULT_FLAGS, RST_FAULT_FLAGS);
    rd(OFF_STATUS_CTRL, RST_STATUS_CTRL);
    rd(4'hF, 32'h0);
    $display("test reset done");
    acc = 32'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      acc[bt[i]] = 1'b1;
      ev(NUM_SRC'(1 << i), 64'hFFFF, 1'b1, 1'b0);
      rd(OFF_FAULT_FLAGS, acc);
      rs;
    end
    wr(OFF_FAULT_FLAGS, 32'hFFFF_FFFF);
    rd(OFF_FAULT_FLAGS, 32'h0);
    $display("test flags done");
    ev('0, 64'h3F9, 1'b0, 1'b0);
    ev('0, 64'h3F8, 1'b1, 1'b0);
    rs;
    wide64 <= 1'b1;
    ev('0, 64'h5F4, 1'b1, 1'b0);
    rs;
    ev('0, 64'h5F5, 1'b0, 1'b0);
    rd(OFF_FAULT_FLAGS, 32'h2);
    wr(OFF_FAULT_FLAGS, 32'h2);
    $display("test region done");
    ha = $urandom;
    wr(OFF_HANDLER_ADDR, ha);
    wr(OFF_STATUS_CTRL, 32'h12);
    inHandler <= 1'b1;
    handlerIrqId <= ha[7:0];
    ev(NUM_SRC'(8), 64'hFFFF, 1'b0, 1'b1);
    chk(redirectAddr, ha);
    chk(restartPc, pc);
    chkb(redirectLogical, 1'b1);
    chkb(pagingOn, 1'b1);
    inHandler <= 1'b0;
    rd(OFF_FAULT_FLAGS, {ha[7:0], 24'h00_2100});
    taskLoad <= 1'b1;
    @(posedge clock);
    taskLoad <= 1'b0;
    #1;
    chkb(pagingOn, 1'b0);
    ev(NUM_SRC'(128), 64'hFFFF, 1'b0, 1'b1);
    chkb(redirectLogical, 1'b0);
    chkb(irq, 1'b0);
    wr(OFF_IRQ_MASK, 32'h0000_1000);
    #1;
    chkb(irq, 1'b1);
    wr(OFF_FAULT_FLAGS, 32'h0000_1000);
    #1;
    chkb(irq, 1'b0);
    $display("test handler done");
    repeat (2) @(posedge clock);
    conclude;
  end
endmodule
